// [tip_defs.svh]
// Constants of the instruction-path block: capture pattern, instruction width, reset instruction.
// Assumes inclusion by the package and the design files; definitions only.
`ifndef TIP_DEFS_SVH
`define TIP_DEFS_SVH
`define TIP_IR_WIDTH 3
`define TIP_CAPTURE_PATTERN 3'h4
`define TIP_IR_RESET 3'h1
`endif

// [tip_pkg.sv]
// Types shared by the instruction-path block.
// Assumes tip_defs.svh is on the include path.
`include "tip_defs.svh"
package tip_pkg;
    typedef enum logic [3:0] {
        TIP_RESET, TIP_IDLE, TIP_SEL_DR, TIP_CAP_DR, TIP_SHIFT_DR, TIP_EXIT1_DR,
        TIP_PAUSE_DR, TIP_EXIT2_DR, TIP_UPD_DR, TIP_SEL_IR, TIP_CAP_IR, TIP_SHIFT_IR,
        TIP_EXIT1_IR, TIP_PAUSE_IR, TIP_EXIT2_IR, TIP_UPD_IR
    } tip_state_t;
    typedef struct packed {
        logic tms;
        logic tdi;
    } tip_pins_t;
    typedef struct packed {
        logic valid;
        logic [`TIP_IR_WIDTH-1:0] instr;
    } tip_instr_t;
endpackage : tip_pkg

// [tip_sync.sv]
// Two-flop synchroniser for a group of levels.
// Assumes the inputs are asynchronous to i_clock.
`timescale 1ns/1ps
module tip_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;
    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end
    assign o_sync = sync_q;
endmodule : tip_sync

// [tip_tap.sv]
// Test access port: state machine, instruction shift path and update latch.
// Assumes i_tck comes from the external tester; i_trst_n is synchronous to it.
// Contract
// [R1] Exit1-IR: TMS high update, low pause
// [R2] Exit2-IR: TMS high update, low shift
// [R3] Pause-IR holds on low, exits on high
// [R4] Pause-IR freezes instruction shift contents
// [R5] Exit and pause keep instruction, data
// [R6] Update-IR latches instruction on falling TCK
// [R7] Latched instruction becomes current instruction
// [R8] Update-IR leaves data registers unchanged
// [R9] Tester drives TMS high to apply
// [R10] Shift-IR shifts TDI to TDO, exits
// [R11] Capture-IR preloads pattern 100
// [R12] Update-IR goes select-DR or idle
`timescale 1ns/1ps
`include "tip_defs.svh"
module tip_tap
    import tip_pkg::*;
#(
    parameter int IR_WIDTH = `TIP_IR_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire tip_pins_t i_pins,
    output logic o_tdo,
    output logic o_tdo_oe_n,
    output logic [IR_WIDTH-1:0] o_instr,
    output logic o_instr_new,
    output logic [3:0] o_state
);
    tip_state_t state_q;
    tip_state_t state_d;
    logic [IR_WIDTH-1:0] ir_shift_q;
    logic [IR_WIDTH-1:0] ir_shift_d;
    // Update latch on falling TCK, as the instruction must settle before the next rise
    logic [IR_WIDTH-1:0] ir_par_q;
    logic [IR_WIDTH-1:0] ir_par_d;
    logic upd_tgl_q;
    logic upd_tgl_d;
    logic tms;
    logic tdi;
    assign tms = i_pins.tms;
    assign tdi = i_pins.tdi;

    always_comb begin
        state_d = state_q;
        case (state_q)
            TIP_RESET: state_d = tms ? TIP_RESET : TIP_IDLE;
            TIP_IDLE: state_d = tms ? TIP_SEL_DR : TIP_IDLE;
            TIP_SEL_DR: state_d = tms ? TIP_SEL_IR : TIP_CAP_DR;
            TIP_CAP_DR: state_d = tms ? TIP_EXIT1_DR : TIP_SHIFT_DR;
            TIP_SHIFT_DR: state_d = tms ? TIP_EXIT1_DR : TIP_SHIFT_DR;
            TIP_EXIT1_DR: state_d = tms ? TIP_UPD_DR : TIP_PAUSE_DR;
            TIP_PAUSE_DR: state_d = tms ? TIP_EXIT2_DR : TIP_PAUSE_DR;
            TIP_EXIT2_DR: state_d = tms ? TIP_UPD_DR : TIP_SHIFT_DR;
            TIP_UPD_DR: state_d = tms ? TIP_SEL_DR : TIP_IDLE;
            TIP_SEL_IR: state_d = tms ? TIP_RESET : TIP_CAP_IR;
            TIP_CAP_IR: state_d = tms ? TIP_EXIT1_IR : TIP_SHIFT_IR;
            TIP_SHIFT_IR: state_d = tms ? TIP_EXIT1_IR : TIP_SHIFT_IR; // [R10]
            TIP_EXIT1_IR: state_d = tms ? TIP_UPD_IR : TIP_PAUSE_IR; // [R1] [R9]
            TIP_PAUSE_IR: state_d = tms ? TIP_EXIT2_IR : TIP_PAUSE_IR; // [R3]
            TIP_EXIT2_IR: state_d = tms ? TIP_UPD_IR : TIP_SHIFT_IR; // [R2] [R9]
            TIP_UPD_IR: state_d = tms ? TIP_SEL_DR : TIP_IDLE; // [R12]
            default: state_d = TIP_RESET;
        endcase
    end

    always_comb begin
        ir_shift_d = ir_shift_q;
        case (state_q)
            // Fixed capture value lets the tester see a broken serial path
            TIP_CAP_IR: ir_shift_d = IR_WIDTH'(`TIP_CAPTURE_PATTERN); // [R11]
            TIP_SHIFT_IR: ir_shift_d = {tdi, ir_shift_q[IR_WIDTH-1:1]}; // [R10]
            // Exit, pause and update keep the shift path frozen
            default: ir_shift_d = ir_shift_q; // [R4] [R5]
        endcase
    end

    always_ff @(posedge i_tck) begin
        if (!i_trst_n) begin
            state_q <= TIP_RESET;
            ir_shift_q <= IR_WIDTH'(`TIP_IR_RESET);
        end else begin
            state_q <= state_d;
            ir_shift_q <= ir_shift_d;
        end
    end

    always_comb begin
        ir_par_d = ir_par_q; // [R5] [R8]
        upd_tgl_d = upd_tgl_q;
        if (state_q == TIP_RESET) begin
            ir_par_d = IR_WIDTH'(`TIP_IR_RESET);
            // Reset instruction must reach the clock side too, but only once
            if (ir_par_q != IR_WIDTH'(`TIP_IR_RESET)) begin
                upd_tgl_d = ~upd_tgl_q;
            end
        end else if (state_q == TIP_UPD_IR) begin
            ir_par_d = ir_shift_q; // [R6] [R7]
            upd_tgl_d = ~upd_tgl_q;
        end
    end

    always_ff @(negedge i_tck) begin
        // A test reset clears the toggle, so the clock side's copy follows only if the toggle was set
        if (!i_trst_n) begin
            ir_par_q <= IR_WIDTH'(`TIP_IR_RESET);
            upd_tgl_q <= 1'b0;
        end else begin
            ir_par_q <= ir_par_d;
            upd_tgl_q <= upd_tgl_d;
        end
    end

    // Output side on i_clock; the word changes on the same TCK edge as the toggle and is held stable after it
    logic [IR_WIDTH+4:0] cross_sync;
    tip_sync #(.WIDTH(IR_WIDTH + 5)) u_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_async({upd_tgl_q, ir_par_q, state_q}),
        .o_sync(cross_sync)
    );

    logic tgl_seen_q;
    logic tgl_seen_d;
    logic tgl_old_q;
    logic tgl_old_d;
    logic [IR_WIDTH-1:0] instr_q;
    logic [IR_WIDTH-1:0] instr_d;
    logic instr_new_q;
    logic instr_new_d;

    logic [3:0] state_seen_q;
    logic [3:0] state_seen_d;
    logic [3:0] state_out_q;
    logic [3:0] state_out_d;

    logic tdo_out_q;
    logic tdo_out_d;
    logic tdo_oe_out_q;
    logic tdo_oe_out_d;

    // Word is read a cycle after its toggle, so every word bit has resolved by then
    // Two updates closer than one clock cycle would cancel in the toggle and go unseen
    always_comb begin
        tgl_seen_d = cross_sync[IR_WIDTH+4];
        tgl_old_d = tgl_seen_q;
        instr_new_d = tgl_seen_q ^ tgl_old_q;
        instr_d = instr_q;
        if (instr_new_d) begin
            instr_d = cross_sync[IR_WIDTH+3:4]; // [R7]
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            tgl_seen_q <= 1'b0;
            tgl_old_q <= 1'b0;
            instr_q <= IR_WIDTH'(`TIP_IR_RESET);
            instr_new_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_seen_d;
            tgl_old_q <= tgl_old_d;
            instr_q <= instr_d;
            instr_new_q <= instr_new_d;
        end
    end

    // State is informative only; a value caught mid-change is dropped unless seen twice
    // No handshake here, as TCK may stop between scans
    always_comb begin
        state_seen_d = cross_sync[3:0];
        state_out_d = state_out_q;
        if (cross_sync[3:0] == state_seen_q) begin
            state_out_d = state_seen_q;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_seen_q <= 4'h0;
            state_out_q <= 4'h0;
        end else begin
            state_seen_q <= state_seen_d;
            state_out_q <= state_out_d;
        end
    end

    // TDO moves on falling TCK so the tester samples it settled on the rise
    always_comb begin
        tdo_out_d = tdo_out_q;
        tdo_oe_out_d = 1'b1;
        if (state_q == TIP_SHIFT_IR) begin
            tdo_out_d = ir_shift_q[0]; // [R10]
            tdo_oe_out_d = 1'b0;
        end
    end

    always_ff @(negedge i_tck) begin
        if (!i_trst_n) begin
            tdo_out_q <= 1'b0;
            tdo_oe_out_q <= 1'b1;
        end else begin
            tdo_out_q <= tdo_out_d;
            tdo_oe_out_q <= tdo_oe_out_d;
        end
    end

    assign o_tdo = tdo_out_q;
    assign o_tdo_oe_n = tdo_oe_out_q;
    assign o_instr = instr_q;
    assign o_instr_new = instr_new_q;
    assign o_state = state_out_q;
endmodule : tip_tap

// [tip_tap_bench.sv]
// Self-checking bench of the tap's instruction path.
// Assumes the tester model owns TCK; instruction read in the clock domain.
`timescale 1ns/1ps
`include "tip_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tip_tap_bench
    import tip_pkg::*;
;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic i_trst_n = 1'b0;
    logic tck, tdo, oe_n, new_pulse, t;
    tip_pins_t pins;
    logic [2:0] instr, ir, got;
    logic [3:0] state;
    int n_errors = 0, comparisons = 0, pulses = 0, k, n;
    integer seed = 20360;
    always #50 i_clock = ~i_clock;
    always @(negedge i_clock) if (new_pulse) pulses++;
    tip_tap dut (.i_clock(i_clock), .i_rst(i_rst), .i_tck(tck), .i_trst_n(i_trst_n),
        .i_pins(pins), .o_tdo(tdo), .o_tdo_oe_n(oe_n), .o_instr(instr),
        .o_instr_new(new_pulse), .o_state(state));
    tip_tester tst (.i_tdo(tdo), .o_tck(tck), .o_pins(pins));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
    initial begin
        tst.step(1'b1, 1'b0, t);
        repeat (20) @(negedge i_clock);
        i_rst = 1'b0;
        i_trst_n = 1'b1;
        tst.step(1'b0, 1'b0, t);
        for (k = 0; k < 9; k++) begin
            ir = (k == 0) ? 3'h7 : 3'($random(seed));
            n = pulses;
            tst.scan(ir, k % 3, 1 + k % 4, got);
            tst.step(k[0], ~ir[2], t);
            // Far apart so the toggle crossing cannot cancel updates
            repeat (8) @(negedge i_clock);
            `CHK(got, `TIP_CAPTURE_PATTERN)
            `CHK(instr, ir)
            `CHK(pulses - n, 1)
            `CHK(state, k[0] ? 4'(TIP_SEL_DR) : 4'(TIP_IDLE))
            if (k[0]) for (n = 0; n < 4; n++) tst.step(n == 1 || n == 2, 1'b0, t);
            $display("test %0d done", k);
        end
        // Five TMS highs reach test-logic-reset, which restores the reset instruction
        for (n = 0; n < 6; n++) tst.step(n < 5, 1'b0, t);
        repeat (8) @(negedge i_clock);
        `CHK(instr, `TIP_IR_RESET)
        `CHK(state, 4'(TIP_IDLE))
        $display("test reset done");
        test_done();
    end
endmodule : tip_tap_bench

// [tip_tap_checker.sv]
// Port checks of the tap's instruction path.
// Assumes binding to tip_tap; TCK checks only see edges inside scans.
`timescale 1ns/1ps
`include "tip_defs.svh"
module tip_tap_checker
    import tip_pkg::*;
#(
    parameter int IR_WIDTH = 3
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tck,
    input wire logic i_trst_n,
    input wire tip_pins_t i_pins,
    input wire logic o_tdo,
    input wire logic o_tdo_oe_n,
    input wire logic [IR_WIDTH-1:0] o_instr,
    input wire logic o_instr_new,
    input wire logic [3:0] o_state
);
    logic tms;
    assign tms = i_pins.tms;
    // Enable low marks the shift state
    sequence s_ex1;
        !o_tdo_oe_n && tms;
    endsequence
    AST_SHIFT_STAY: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        !o_tdo_oe_n && !tms |=> !o_tdo_oe_n) else $error("shift left early");
    AST_SHIFT_EXIT: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_ex1 |=> o_tdo_oe_n) else $error("shift not left");
    AST_PAUSE_BACK: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_ex1 ##1 !tms ##1 tms ##1 !tms |=> !o_tdo_oe_n) else $error("no return to shift");
    AST_EXIT_UPD: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        s_ex1 ##1 tms ##1 !tms |=> o_tdo_oe_n) else $error("shift after update");
    AST_TRST_OFF: assert property (@(posedge i_tck) disable iff (!i_trst_n)
        $rose(i_trst_n) |-> o_tdo_oe_n) else $error("driving after reset");
    AST_NEW_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
        o_instr_new |=> !o_instr_new) else $error("update pulse too long");
    AST_INSTR_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(o_instr) |-> o_instr_new) else $error("instruction changed alone");
    AST_INSTR_RST: assert property (@(posedge i_clock) disable iff (i_rst)
        $fell(i_rst) |-> o_instr == `TIP_IR_RESET) else $error("bad reset instruction");
endmodule : tip_tap_checker
bind tip_tap tip_tap_checker #(.IR_WIDTH(IR_WIDTH)) u_chk (.i_clock(i_clock), .i_rst(i_rst),
    .i_tck(i_tck), .i_trst_n(i_trst_n), .i_pins(i_pins), .o_tdo(o_tdo),
    .o_tdo_oe_n(o_tdo_oe_n), .o_instr(o_instr), .o_instr_new(o_instr_new), .o_state(o_state));

// [tip_tester.sv]
// Tester model driving TCK, TMS and TDI of the tap.
// Assumes the bench calls its tasks; TCK rests low between scans.
`timescale 1ns/1ps
module tip_tester
    import tip_pkg::*;
(
    input wire logic i_tdo,
    output logic o_tck,
    output tip_pins_t o_pins
);
    initial begin
        o_tck = 1'b0;
        o_pins = '0;
    end
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_pins = '{tms: tms, tdi: tdi};
        #16 o_tck = 1'b1;
        tdo = i_tdo;
        #16 o_tck = 1'b0;
    endtask : step
    // Mode 1 pauses mid-scan, mode 2 after the last bit; idle TDI is inverted
    task automatic scan(input logic [2:0] ir, input int m, input int p, output logic [2:0] got);
        logic t;
        for (int i = 0; i < 4; i++) step(i < 2, ~ir[0], t);
        for (int i = 0; i < 3; i++) begin
            step(i == 2 || (m == 1 && i == 1), ir[i], got[i]);
            if ((m == 1 && i == 1) || (m == 2 && i == 2)) begin
                repeat (p) step(1'b0, ~ir[i], t);
                step(1'b1, ~ir[i], t);
                if (m == 1) step(1'b0, ~ir[i], t);
            end
        end
        step(1'b1, ~ir[2], t);
    endtask : scan
endmodule : tip_tester
